/* File: bstap_top.sv */
// boundary-scan test access port controller
`timescale 1ns/10ps
`default_nettype none
module bstap_top (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  // test port pins
  input  wire logic                           tck,
  input  wire logic                           tms,
  input  wire logic                           tdi,
  input  wire logic                           trst_n,
  output var  logic                           tdo,
  output var  logic                           tdo_oe,
  // pin side
  input  wire logic [bstap_pkg::CHAIN_W-1:0]  pin_state,
  output var  logic [bstap_pkg::CHAIN_W-1:0]  pin_drive,
  output var  logic                           pin_drive_en,
  output var  logic                           pin_float,
  output var  logic                           test_lock
);
  import bstap_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] tck_s_r;
  logic       tck_d_r;
  logic [1:0] tms_s_r;
  logic [1:0] tdi_s_r;
  logic [1:0] trst_s_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_s_r  <= 2'h0;
      tck_d_r  <= 1'b0;
      tms_s_r  <= 2'h3;
      tdi_s_r  <= 2'h3;
      trst_s_r <= 2'h3;
    end else begin
      tck_s_r  <= {tck_s_r[0], tck};
      tck_d_r  <= tck_s_r[1];
      tms_s_r  <= {tms_s_r[0], tms};
      tdi_s_r  <= {tdi_s_r[0], tdi};
      trst_s_r <= {trst_s_r[0], trst_n};
    end
  end

  wire tck_rise = tck_s_r[1] & ~tck_d_r;
  wire tck_fall = ~tck_s_r[1] & tck_d_r;
  wire tms_q    = tms_s_r[1];
  wire tdi_q    = tdi_s_r[1];
  wire trst_act = ~trst_s_r[1];

  // ----------------------------------------------------------------
  // pin level synchroniser for capture
  // ----------------------------------------------------------------
  logic [CHAIN_W-1:0] pins_m_r;
  logic [CHAIN_W-1:0] pins_q_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_m_r <= '0;
      pins_q_r <= '0;
    end else begin
      pins_m_r <= pin_state;
      pins_q_r <= pins_m_r;
    end
  end

  // ----------------------------------------------------------------
  // state graph
  // ----------------------------------------------------------------
  function automatic bstap_state_t tap_next(input bstap_state_t s,
                                            input logic m);
    case (s)
      ST_RESET:  tap_next = m ? ST_RESET  : ST_IDLE;
      ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: tap_next = m ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: tap_next = m ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction : tap_next

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  bstap_state_t state_r;
  bstap_state_t state_nxt;

  assign state_nxt = tap_next(state_r, tms_q);

  always_ff @(posedge clk) begin
    if (sys_rst || trst_act) begin
      state_r <= ST_RESET;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // state decode, actions on rising test clock
  // ----------------------------------------------------------------
  wire in_reset = (state_r == ST_RESET);
  wire do_cap_dr = tck_rise & (state_r == ST_CAP_DR);
  wire do_shf_dr = tck_rise & (state_r == ST_SHF_DR);
  wire do_upd_dr = tck_rise & (state_r == ST_UPD_DR);
  wire do_cap_ir = tck_rise & (state_r == ST_CAP_IR);
  wire do_shf_ir = tck_rise & (state_r == ST_SHF_IR);
  wire do_upd_ir = tck_rise & (state_r == ST_UPD_IR);

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [IR_W-1:0] ir_shift_r;
  logic [IR_W-1:0] instruction_register_r;

  always_ff @(posedge clk) begin
    if (sys_rst || trst_act) begin
      ir_shift_r <= IR_CAPTURE_VAL;
    end else if (do_cap_ir) begin
      ir_shift_r <= IR_CAPTURE_VAL;
    end else if (do_shf_ir) begin
      ir_shift_r <= {tdi_q, ir_shift_r[IR_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // instruction latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || trst_act || in_reset) begin
      instruction_register_r <= IR_RESET_VAL;
    end else if (do_upd_ir) begin
      instruction_register_r <= ir_shift_r;
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  function automatic bstap_sel_t sel_of(input logic [IR_W-1:0] c);
    case (c)
      INS_EXTEST: sel_of = SEL_CHAIN;
      INS_SAMPLE: sel_of = SEL_CHAIN;
      INS_IDREAD: sel_of = SEL_ID;
      default:    sel_of = SEL_PASS;
    endcase
  endfunction : sel_of

  bstap_sel_t sel;
  assign sel = sel_of(instruction_register_r);
  wire is_extest = (instruction_register_r == INS_EXTEST);
  wire is_float  = (instruction_register_r == INS_FLOAT);
  wire pick_chain = (sel == SEL_CHAIN);
  wire pick_id    = (sel == SEL_ID);
  wire pick_pass  = (sel == SEL_PASS);

  // ----------------------------------------------------------------
  // data register actions per selected register
  // ----------------------------------------------------------------
  wire id_cap    = do_cap_dr & pick_id;
  wire id_shf    = do_shf_dr & pick_id;
  wire pass_cap  = do_cap_dr & pick_pass;
  wire pass_shf  = do_shf_dr & pick_pass;
  wire chain_cap = do_cap_dr & pick_chain;
  wire chain_shf = do_shf_dr & pick_chain;
  wire chain_upd = do_upd_dr & pick_chain;

  // ----------------------------------------------------------------
  // identification and pass stage
  // ----------------------------------------------------------------
  logic [ID_W-1:0] id_shift_r;
  logic            single_bit_pass_stage_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_shift_r <= ID_VALUE;
    end else if (id_cap) begin
      id_shift_r <= ID_VALUE;
    end else if (id_shf) begin
      id_shift_r <= {tdi_q, id_shift_r[ID_W-1:1]};
    end
  end

  // ----------------------------------------------------------------
  // single-bit pass stage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_bit_pass_stage_r <= 1'b0;
    end else if (pass_cap) begin
      single_bit_pass_stage_r <= 1'b0;
    end else if (pass_shf) begin
      single_bit_pass_stage_r <= tdi_q;
    end
  end

  // ----------------------------------------------------------------
  // pin scan chain
  // ----------------------------------------------------------------
  bstap_chain_if chain_bus ();

  assign chain_bus.capture   = chain_cap;
  assign chain_bus.shift     = chain_shf;
  assign chain_bus.update    = chain_upd;
  assign chain_bus.serial_in = tdi_q;

  bstap_pin_chain u_pin_scan_chain (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ctl       (chain_bus.chain),
    .pin_state (pins_q_r),
    .latch_q   (pin_drive)
  );

  // ----------------------------------------------------------------
  // serial output, changes on falling test clock
  // ----------------------------------------------------------------
  wire shifting_ir = (state_r == ST_SHF_IR);
  wire shifting_dr = (state_r == ST_SHF_DR);
  wire shifting    = shifting_ir | shifting_dr;
  wire dr_bit = pick_chain ? chain_bus.serial_out :
                pick_id    ? id_shift_r[0] :
                             single_bit_pass_stage_r;
  wire out_bit = shifting_ir ? ir_shift_r[0] : dr_bit;

  // ----------------------------------------------------------------
  // serial output register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || trst_act) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= out_bit;
      tdo_oe <= shifting;
    end
  end

  // ----------------------------------------------------------------
  // pin control
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_drive_en <= 1'b0;
      pin_float    <= 1'b0;
    end else begin
      pin_drive_en <= is_extest;
      pin_float    <= is_float;
    end
  end

  // ----------------------------------------------------------------
  // extest lock, cleared by device reset only
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_lock <= 1'b0;
    end else if (is_extest) begin
      test_lock <= 1'b1;
    end
  end

endmodule : bstap_top
`default_nettype wire

/* File: bstap_pkg.sv */
// constants and types for the boundary-scan test access port
package bstap_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned IR_W    = 5;
  localparam int unsigned ID_W    = 32;
  localparam int unsigned CHAIN_W = 297;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [4:0] INS_EXTEST = 5'h00;
  localparam logic [4:0] INS_SAMPLE = 5'h01;
  localparam logic [4:0] INS_IDREAD = 5'h02;
  localparam logic [4:0] INS_FLOAT  = 5'h03;
  localparam logic [4:0] INS_BYPASS = 5'h1F;

  // ----------------------------------------------------------------
  // capture and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] IR_CAPTURE_VAL = 5'h01;
  localparam logic [4:0] IR_RESET_VAL   = INS_IDREAD;

  // ----------------------------------------------------------------
  // identification fields (values arbitrary, not a real part)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ID_REVISION = 4'h1;
  localparam logic [15:0] ID_PART     = 16'h1234;
  localparam logic [10:0] ID_MAKER    = 11'h055;
  localparam logic [31:0] ID_VALUE    = {ID_REVISION, ID_PART, ID_MAKER,
                                         1'b1};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHF_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHF_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR,
    ST_UPD_IR
  } bstap_state_t;

  typedef enum logic [1:0] {
    SEL_CHAIN, SEL_ID, SEL_PASS
  } bstap_sel_t;

endpackage : bstap_pkg

/* File: bstap_chain_if.sv */
// control and serial signals between the tap and the pin scan chain
`timescale 1ns/10ps
`default_nettype none
interface bstap_chain_if;
  logic capture;
  logic shift;
  logic update;
  logic serial_in;
  logic serial_out;

  modport tap   (output capture, output shift, output update,
                 output serial_in, input serial_out);
  modport chain (input capture, input shift, input update,
                 input serial_in, output serial_out);
endinterface : bstap_chain_if
`default_nettype wire

/* File: bstap_pin_chain.sv */
// pin scan chain: shift stage and output latch
`timescale 1ns/10ps
`default_nettype none
module bstap_pin_chain (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  // tap side
  bstap_chain_if.chain                        ctl,
  // pins
  input  wire logic [bstap_pkg::CHAIN_W-1:0]  pin_state,
  output var  logic [bstap_pkg::CHAIN_W-1:0]  latch_q
);
  import bstap_pkg::*;

  logic [CHAIN_W-1:0] shift_r;
  logic [CHAIN_W-1:0] latch_r;

  assign ctl.serial_out = shift_r[0];
  assign latch_q        = latch_r;

  // ----------------------------------------------------------------
  // shift stage and latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= '0;
    end else if (ctl.capture) begin
      shift_r <= pin_state;
    end else if (ctl.shift) begin
      shift_r <= {ctl.serial_in, shift_r[CHAIN_W-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_r <= '0;
    end else if (ctl.update) begin
      latch_r <= shift_r;
    end
  end

endmodule : bstap_pin_chain
`default_nettype wire

/* File: bstap_checker.sv */
// assertions on the tap top ports
`timescale 1ns/10ps
`default_nettype none
module bstap_checker (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          sys_rst,
  // test port
  input wire logic                          tck,
  input wire logic                          tdo,
  input wire logic                          tdo_oe,
  // pin side
  input wire logic [bstap_pkg::CHAIN_W-1:0] pin_drive,
  input wire logic                          pin_drive_en,
  input wire logic                          pin_float,
  input wire logic                          test_lock
);
  import bstap_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  reset_clears_a: assert property (disable iff (1'b0)
    sys_rst |=> !pin_drive_en && !pin_float && !test_lock && !tdo_oe
      && pin_drive == '0) else $error("outputs not cleared by reset");
  lock_holds_a: assert property (test_lock |=> test_lock)
    else $error("lock dropped without reset");
  lock_cause_a: assert property ($rose(test_lock) |->
    pin_drive_en || $past(pin_drive_en)) else $error("lock without drive");
  drive_float_excl_a: assert property (!(pin_drive_en && pin_float))
    else $error("drive and float together");
  latch_on_rise_a: assert property ($changed(pin_drive) |->
    tck && !tdo_oe) else $error("latch moved outside update");
  tdo_on_fall_a: assert property ($changed(tdo) |-> !tck)
    else $error("serial out moved while clock high");
  oe_on_fall_a: assert property ($changed(tdo_oe) |-> !tck)
    else $error("output enable moved while clock high");
  drive_steady_a: assert property ($changed(pin_drive_en) |->
    !tdo_oe) else $error("drive enable moved during a shift");
  cover property ($rose(pin_drive_en));
  cover property ($rose(pin_float));
  cover property ($rose(tdo_oe));
endmodule : bstap_checker
bind bstap_top bstap_checker bstap_checker_i (.clk(clk), .sys_rst(sys_rst),
  .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe), .pin_drive(pin_drive),
  .pin_drive_en(pin_drive_en), .pin_float(pin_float),
  .test_lock(test_lock));
`default_nettype wire

/* File: bstap_tester.sv */
// scan tester model driving the test port pins
`timescale 1ns/10ps
`default_nettype none
module bstap_tester (
  // clock
  input  wire logic clk,
  // test port
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one test clock period, tms set up while tck low
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    tck = 1'b1;
    repeat (4) @(negedge clk);
    q = tdo;
    tck = 1'b0;
  endtask : step
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n,
                      input logic [296:0] din, output logic [296:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    repeat (8) @(negedge clk);
  endtask : scan
  // one test clock with tms low: from test-logic-reset to idle
  task automatic go_idle();
    logic q;
    step(1'b0, 1'b1, q);
    repeat (8) @(negedge clk);
  endtask : go_idle
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    go_idle();
  endtask : reset5
endmodule : bstap_tester
`default_nettype wire

/* File: bstap_top_tb.sv */
// self-checking bench for the boundary-scan tap
`timescale 1ns/10ps
`default_nettype none
module bstap_top_tb;
  import bstap_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst, trst_n, tck, tms, tdi, tdo, tdo_oe;
  logic [296:0] pin_state, pin_drive, o;
  logic         pin_drive_en, pin_float, test_lock;
  int           miscompares = 0;
  int           total_checks = 0;
  int           cycles = 0;
  logic [4:0]   codes [5] = '{5'h03, 5'h04, 5'h0A, 5'h1E, 5'h1F};
  always #25 clk = ~clk;
  bstap_top bstap_top_i (.clk(clk), .sys_rst(sys_rst), .tck(tck),
    .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .pin_state(pin_state), .pin_drive(pin_drive),
    .pin_drive_en(pin_drive_en), .pin_float(pin_float),
    .test_lock(test_lock));
  bstap_tester bstap_tester_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [296:0] got, input logic [296:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic id_read();
    bstap_tester_i.scan(1'b0, 32, '1, o);
    check(o[31:0], {ID_REVISION, ID_PART, ID_MAKER, 1'b1});
    check(o[0], 1'b1);
  endtask : id_read
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  task automatic t_idcode();
    id_read();
    check({pin_drive_en, pin_float, test_lock}, 3'h0);
    $display("test idcode done");
  endtask : t_idcode
  task automatic t_bypass();
    foreach (codes[k]) begin
      bstap_tester_i.scan(1'b1, 5, codes[k], o);
      check(o[4:0], 5'h01);
      check(pin_float, codes[k] == 5'h03);
      bstap_tester_i.scan(1'b0, 8, 8'hA5, o);
      check(o[7:0], 8'h4A);
    end
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_sample();
    pin_state = {99{3'h6}};
    bstap_tester_i.scan(1'b1, 5, 5'h01, o);
    bstap_tester_i.scan(1'b0, 297, {99{3'h5}}, o);
    check(o, {99{3'h6}});
    check(pin_drive, {99{3'h5}});
    check({pin_drive_en, test_lock}, 2'h0);
    $display("test sample done");
  endtask : t_sample
  task automatic t_extest();
    pin_state = {99{3'h3}};
    bstap_tester_i.scan(1'b1, 5, 5'h00, o);
    check({pin_drive_en, test_lock}, 2'h3);
    bstap_tester_i.scan(1'b0, 297, {99{3'h2}}, o);
    check(o, {99{3'h3}});
    check(pin_drive, {99{3'h2}});
    bstap_tester_i.reset5();
    check({pin_drive_en, test_lock}, 2'h1);
    id_read();
    bstap_tester_i.scan(1'b1, 5, 5'h1F, o);
    trst_n = 1'b0;
    repeat (8) @(negedge clk);
    trst_n = 1'b1;
    repeat (4) @(negedge clk);
    bstap_tester_i.go_idle();
    id_read();
    sys_rst = 1'b1;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    check(test_lock, 1'b0);
    $display("test extest done");
  endtask : t_extest
  // ------------------------------------------------------------
  // main sequence and timeout
  // ------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    trst_n = 1'b1;
    pin_state = '0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    bstap_tester_i.go_idle();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    tally_and_finish();
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
endmodule : bstap_top_tb
`default_nettype wire
